// ---- include/see_pkg.sv ----
`default_nettype none
package see_pkg;
  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 9; // 512-byte variant
  localparam int PAGE_BITS = 3; // eight bytes per page
  localparam int PAGE_BYTES = 8;
  // ---------------------------------------------------------------
  // opcode fields: upper nibble zero, bit 3 address or don't-care
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_HI = 4'h0;
  localparam int OP_ADDR_BIT = 3;
  localparam logic [2:0] OP_SET_LATCH = 3'h6;
  localparam logic [2:0] OP_CLR_LATCH = 3'h4;
  localparam logic [2:0] OP_STAT_RD = 3'h5;
  localparam logic [2:0] OP_STAT_WR = 3'h1;
  localparam logic [2:0] OP_MEM_RD = 3'h3;
  localparam logic [2:0] OP_MEM_WR = 3'h2;
  // ---------------------------------------------------------------
  // status byte layout
  // ---------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_PROT_LO = 2;
  localparam int ST_PROT_HI = 3;
  localparam logic [7:0] ST_ALL_ONES = 8'hFF;
  localparam logic [1:0] PROT_RESET = 2'h0; // nonvolatile cells start unprotected
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int T_WC_NS = 5000000; // longest self-timed write cycle
  localparam int WC_CYCLES = T_WC_NS / CLK_NS;
  localparam int HOST_HALF_CYCLES = 8; // host sck half period in clk cycles
  // ---------------------------------------------------------------
  // host command registers
  // ---------------------------------------------------------------
  localparam logic [3:0] HREG_CTRL = 4'h0;
  localparam logic [3:0] HREG_TX = 4'h1;
  localparam logic [3:0] HREG_RX = 4'h2;
  localparam logic [3:0] HREG_STAT = 4'h3;
  localparam int CTRL_SELECT = 0;
  localparam int CTRL_PAUSE = 1;
  localparam int CTRL_INHIBIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
endpackage
`default_nettype wire

// ---- include/see_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface see_link_if;
  logic csN; // chip select, active low
  logic sck; // serial clock, idles low
  logic si; // master to device data
  logic soOut; // device data value
  logic soOe; // device drives so
  logic holdN; // pause, active low
  logic wpN; // write inhibit, active low
  logic soBus; // resolved so line, pulled high when floating
  assign soBus = soOe ? soOut : 1'b1;
  modport dev (input csN, input sck, input si, input holdN, input wpN, output soOut, output soOe);
  modport host (output csN, output sck, output si, output holdN, output wpN, input soBus);
endinterface
`default_nettype wire

// ---- verilog/see_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module see_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q; // first stage, read only by the second
  // ---------------------------------------------------------------
  // two-flop synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/see_dev_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module see_dev_end
#(
  parameter int AddrW = see_pkg::ADDR_W,
  parameter int WriteCycles = see_pkg::WC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  see_link_if.dev link,
  output logic busy,
  output logic writeLatch,
  output logic [1:0] protectLevel
);
  import see_pkg::*;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_OPCODE = 8'h02,
    S_ADDR = 8'h04,
    S_RDATA = 8'h08,
    S_WDATA = 8'h10,
    S_SRDATA = 8'h20,
    S_SWDATA = 8'h40,
    S_IGNORE = 8'h80
  } see_state_e;

  see_state_e state_q, state_d; // sequence state
  logic [4:0] syncBus; // synchronised pins
  logic csS, sckS, siS, holdNS, wpNS;
  logic sckPrev_q, csPrev_q; // edge detectors
  logic [2:0] bitCnt_q; // received bits of current byte
  logic [2:0] outCnt_q; // sent bits of current byte
  logic [7:0] rxShift_q; // incoming byte
  logic [7:0] instr_q; // instruction register
  logic [7:0] txShift_q; // outgoing byte
  logic soBit_q; // so value
  logic txLive_q; // first output bit driven
  logic [AddrW-1:0] addr_q; // read pointer
  logic [AddrW-4:0] pageBase_q; // page write upper address
  logic [2:0] pagePtr_q; // page write low address
  logic [7:0] pageVal_q; // page bytes received
  logic [7:0] pageBuf_q [PAGE_BYTES]; // page write data
  logic [7:0] srByte_q; // status byte received
  logic srGot_q; // status byte complete
  logic cancel_q; // inhibit went low during a write command
  logic wel_q; // write-enable latch
  logic [1:0] bp_q; // protection level cells
  logic [31:0] wcCnt_q; // write cycle countdown
  logic [7:0] mem [2**AddrW]; // array cells

  // ---------------------------------------------------------------
  // pin synchronisation and edges
  // ---------------------------------------------------------------
  see_sync #(.W(5)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({~link.csN, link.sck, link.si, ~link.holdN, ~link.wpN}),
    .q(syncBus)
  );
  assign csS = ~syncBus[4]; // idle-high pins pass inverted, so reset reads idle
  assign sckS = syncBus[3];
  assign siS = syncBus[2];
  assign holdNS = ~syncBus[1];
  assign wpNS = ~syncBus[0];

  // pause gates both edges so the sequence freezes even if sck toggles
  wire paused = ~holdNS;
  wire active = ~csS & ~paused;
  wire sckRise = active & sckS & ~sckPrev_q;
  wire sckFall = active & ~sckS & sckPrev_q;
  wire csFall = ~csS & csPrev_q;
  wire csRise = csS & ~csPrev_q;
  wire byteDone = sckRise & (bitCnt_q == 3'h7);
  wire [7:0] rxByte = {rxShift_q[6:0], siS};

  // ---------------------------------------------------------------
  // opcode decode
  // ---------------------------------------------------------------
  wire opValid = rxByte[7:4] == OP_HI;
  wire opSet = opValid & (rxByte[2:0] == OP_SET_LATCH);
  wire opClr = opValid & (rxByte[2:0] == OP_CLR_LATCH);
  wire opSrRd = opValid & (rxByte[2:0] == OP_STAT_RD);
  wire opSrWr = opValid & (rxByte[2:0] == OP_STAT_WR);
  wire opRd = opValid & (rxByte[2:0] == OP_MEM_RD);
  wire opWr = opValid & (rxByte[2:0] == OP_MEM_WR);
  wire writeOk = wel_q & wpNS;
  wire opcodeDone = byteDone & (state_q == S_OPCODE);
  wire [8:0] fullAddr = {instr_q[OP_ADDR_BIT], rxByte};

  // ---------------------------------------------------------------
  // status byte and protection
  // ---------------------------------------------------------------
  assign busy = wcCnt_q != 32'h0;
  assign writeLatch = wel_q;
  assign protectLevel = bp_q;
  logic [7:0] statusByte;
  always_comb
  begin
    statusByte = 8'h00; // bits 4 to 7 read zero unless busy forces all ones
    statusByte[ST_BUSY] = 1'b0;
    statusByte[ST_LATCH] = wel_q;
    statusByte[ST_PROT_LO] = bp_q[0];
    statusByte[ST_PROT_HI] = bp_q[1];
    if (busy)
    begin
      statusByte = ST_ALL_ONES;
    end
  end
  // a page never straddles a quarter, so checking its base suffices
  wire [1:0] topBits = pageBase_q[AddrW-4 -: 2];
  wire pageProt = (bp_q == 2'h3) | ((bp_q == 2'h2) & topBits[1])
    | ((bp_q == 2'h1) & (topBits == 2'h3));
  wire commonOk = csRise & (bitCnt_q == 3'h0) & ~cancel_q & writeOk;
  wire commitArr = commonOk & (state_q == S_WDATA) & (pageVal_q != 8'h00) & ~pageProt;
  wire commitSr = commonOk & (state_q == S_SWDATA) & srGot_q;
  wire wcDone = wcCnt_q == 32'h1;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    if (csS)
    begin
      state_d = S_IDLE;
    end
    else if (csFall)
    begin
      state_d = S_OPCODE;
    end
    else if (opcodeDone)
    begin
      if (opSrRd)
        state_d = S_SRDATA;
      else if (busy)
        state_d = S_IGNORE;
      else if (opRd | (opWr & writeOk))
        state_d = S_ADDR;
      else if (opSrWr & writeOk)
        state_d = S_SWDATA;
      else
        state_d = S_IGNORE;
    end
    else if (byteDone & (state_q == S_ADDR))
    begin
      state_d = instr_q[2:0] == OP_MEM_RD ? S_RDATA : S_WDATA;
    end
  end

  // ---------------------------------------------------------------
  // edge history and state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_IDLE;
      sckPrev_q <= 1'b0;
      csPrev_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      sckPrev_q <= sckS;
      csPrev_q <= csS;
    end
  end

  // ---------------------------------------------------------------
  // receive shifter and instruction register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bitCnt_q <= 3'h0;
      rxShift_q <= 8'h00;
      instr_q <= 8'h00;
    end
    else if (csFall)
    begin
      bitCnt_q <= 3'h0;
    end
    else if (sckRise)
    begin
      bitCnt_q <= bitCnt_q + 3'h1;
      rxShift_q <= rxByte;
      if (state_q == S_OPCODE && bitCnt_q == 3'h7)
        instr_q <= rxByte;
    end
  end

  // ---------------------------------------------------------------
  // transmit path: load after last input bit, shift on falls
  // ---------------------------------------------------------------
  wire [AddrW-1:0] addrNext = addr_q + AddrW'(1); // wraps to zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txShift_q <= 8'h00;
      soBit_q <= 1'b0;
      outCnt_q <= 3'h0;
      txLive_q <= 1'b0;
      addr_q <= '0;
    end
    else if (csFall)
    begin
      outCnt_q <= 3'h0;
      txLive_q <= 1'b0;
    end
    else if (opcodeDone & opSrRd)
    begin
      txShift_q <= statusByte;
    end
    else if (byteDone & (state_q == S_ADDR))
    begin
      addr_q <= fullAddr[AddrW-1:0];
      txShift_q <= mem[fullAddr[AddrW-1:0]];
    end
    else if (sckFall & ((state_q == S_RDATA) | (state_q == S_SRDATA)))
    begin
      soBit_q <= txShift_q[7];
      txLive_q <= 1'b1;
      outCnt_q <= outCnt_q + 3'h1;
      if (outCnt_q != 3'h7)
        txShift_q <= {txShift_q[6:0], 1'b0};
      else if (state_q == S_RDATA)
      begin
        addr_q <= addrNext;
        txShift_q <= mem[addrNext];
      end
      else
        txShift_q <= statusByte;
    end
  end
  wire outState = (state_q == S_RDATA) | (state_q == S_SRDATA);
  assign link.soOut = soBit_q;
  assign link.soOe = outState & txLive_q & active;

  // ---------------------------------------------------------------
  // page and status capture during a write command
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pageBase_q <= '0;
      pagePtr_q <= 3'h0;
      pageVal_q <= 8'h00;
      srByte_q <= 8'h00;
      srGot_q <= 1'b0;
      cancel_q <= 1'b0;
    end
    else if (csFall)
    begin
      pageVal_q <= 8'h00;
      srGot_q <= 1'b0;
      cancel_q <= ~wpNS; // an inhibit on the restart edge still counts
    end
    else
    begin
      if (~csS & ~wpNS)
        cancel_q <= 1'b1;
      if (byteDone & (state_q == S_ADDR))
      begin
        pageBase_q <= fullAddr[AddrW-1:PAGE_BITS];
        pagePtr_q <= fullAddr[PAGE_BITS-1:0];
      end
      if (byteDone & (state_q == S_WDATA))
      begin
        pageVal_q[pagePtr_q] <= 1'b1;
        pagePtr_q <= pagePtr_q + 3'h1;
      end
      if (byteDone & (state_q == S_SWDATA))
      begin
        srByte_q <= rxByte;
        srGot_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // array cells and page buffer, no reset on data storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (byteDone & (state_q == S_WDATA))
      pageBuf_q[pagePtr_q] <= rxByte; // later bytes overwrite
    if (commitArr)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (pageVal_q[i])
          mem[{pageBase_q, 3'(i)}] <= pageBuf_q[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // latch, protection cells and write cycle timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wel_q <= 1'b0;
      bp_q <= PROT_RESET;
      wcCnt_q <= 32'h0;
    end
    else
    begin
      if (commitArr | commitSr)
        wcCnt_q <= 32'(WriteCycles);
      else if (busy)
        wcCnt_q <= wcCnt_q - 32'h1;
      if (commitSr)
        bp_q <= srByte_q[ST_PROT_HI:ST_PROT_LO];
      if (wcDone | (opcodeDone & opClr & ~busy))
        wel_q <= 1'b0;
      else if (opcodeDone & opSet & wpNS & ~busy)
        wel_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/see_host_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module see_host_end
#(
  parameter int HalfCycles = see_pkg::HOST_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  see_link_if.host link,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata
);
  import see_pkg::*;

  logic [2:0] ctrl_q; // select, pause, inhibit requests
  logic [7:0] tx_q; // byte being sent
  logic [7:0] rx_q; // byte being received
  logic busy_q; // byte transfer running
  logic [7:0] div_q; // sck half-period divider
  logic sck_q; // sck drive
  logic [2:0] bit_q; // bit index
  logic csN_q, holdN_q; // pin drives
  logic soS; // synchronised so

  // ---------------------------------------------------------------
  // so synchroniser
  // ---------------------------------------------------------------
  see_sync #(.W(1)) u_so_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(link.soBus),
    .q(soS)
  );

  wire wrCtrl = regWr & (regAddr == HREG_CTRL);
  wire wrTx = regWr & (regAddr == HREG_TX) & ~busy_q; // ignored while busy
  wire halfEnd = div_q == 8'(HalfCycles - 1);
  wire run = busy_q & holdN_q; // pause freezes sck low, or high if holdN falls on the edge that raises sck

  // ---------------------------------------------------------------
  // control register and pin drives
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RESET;
      csN_q <= 1'b1;
      holdN_q <= 1'b1;
    end
    else
    begin
      if (wrCtrl)
        ctrl_q <= regWdata[2:0];
      // sck is low whenever no byte runs, so cs rises in the low phase
      if (~busy_q)
        csN_q <= ~ctrl_q[CTRL_SELECT];
      if (~sck_q)
        holdN_q <= ~ctrl_q[CTRL_PAUSE];
    end
  end

  // ---------------------------------------------------------------
  // byte shifter: si changes in sck low, so captured on rise
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      busy_q <= 1'b0;
      div_q <= 8'h00;
      sck_q <= 1'b0;
      bit_q <= 3'h0;
    end
    else if (wrTx)
    begin
      tx_q <= regWdata;
      busy_q <= 1'b1;
      div_q <= 8'h00;
      bit_q <= 3'h0;
    end
    else if (run)
    begin
      div_q <= halfEnd ? 8'h00 : div_q + 8'h01;
      if (halfEnd & ~sck_q)
      begin
        sck_q <= 1'b1;
        rx_q <= {rx_q[6:0], soS};
      end
      else if (halfEnd)
      begin
        sck_q <= 1'b0;
        tx_q <= {tx_q[6:0], 1'b0};
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7)
          busy_q <= 1'b0;
      end
    end
  end

  assign link.csN = csN_q;
  assign link.sck = sck_q;
  assign link.si = tx_q[7];
  assign link.holdN = holdN_q;
  assign link.wpN = ~ctrl_q[CTRL_INHIBIT];

  // ---------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // ---------------------------------------------------------------
  wire [7:0] rdMux = (regAddr == HREG_CTRL) ? {5'h00, ctrl_q}
    : (regAddr == HREG_TX) ? tx_q
    : (regAddr == HREG_RX) ? rx_q
    : (regAddr == HREG_STAT) ? {7'h00, busy_q} : 8'h00;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= 8'h00;
    else if (regRd)
      regRdata <= rdMux;
  end
endmodule
`default_nettype wire

// ---- sim/see_link_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// link checker: watches the wire between the two ends
// ------------------------------------------------------------
module see_link_monitor #(
  parameter int WriteCycles = see_pkg::WC_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic sck,
  input wire logic soOe,
  input wire logic holdN,
  input wire logic wpN,
  input wire logic busy,
  input wire logic writeLatch,
  input wire logic [1:0] protectLevel
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  int busyCnt; // length of the running write cycle
  // counts busy cycles so a stuck timer is caught without long repetition
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busyCnt <= 0;
    else
      busyCnt <= busy ? busyCnt + 1 : 0;
  end
  // deselected or paused long enough for the synchronisers to settle
  sequence s_csIdle;
    csN [*4];
  endsequence
  sequence s_paused;
    !holdN [*4];
  endsequence
  property p_csFloat;
    s_csIdle |-> !soOe;
  endproperty
  a_csFloat: assert property (p_csFloat) else $error("so driven while deselected");
  property p_holdFloat;
    s_paused |-> !soOe;
  endproperty
  a_holdFloat: assert property (p_holdFloat) else $error("so driven while paused");
  property p_sckIdle;
    csN |-> !sck;
  endproperty
  a_sckIdle: assert property (p_sckIdle) else $error("sck not idle low");
  property p_latchEnd;
    $fell(busy) |-> ##[0:1] !writeLatch;
  endproperty
  a_latchEnd: assert property (p_latchEnd) else $error("latch kept after cycle");
  property p_busyLen;
    busy |-> busyCnt <= WriteCycles + 2;
  endproperty
  a_busyLen: assert property (p_busyLen) else $error("write cycle too long");
  property p_busyLatch;
    $rose(busy) |-> writeLatch && wpN;
  endproperty
  a_busyLatch: assert property (p_busyLatch) else $error("cycle without latch");
  property p_busyCs;
    $rose(busy) |-> csN;
  endproperty
  a_busyCs: assert property (p_busyCs) else $error("cycle began with cs low");
  property p_latchWp;
    $rose(writeLatch) |-> wpN;
  endproperty
  a_latchWp: assert property (p_latchWp) else $error("latch set with inhibit");
  property p_protChange;
    $changed(protectLevel) |-> busy || $past(busy);
  endproperty
  a_protChange: assert property (p_protChange) else $error("protect bits moved");
  property p_busyNoSet;
    busy && $past(busy) |-> !$rose(writeLatch);
  endproperty
  a_busyNoSet: assert property (p_busyNoSet) else $error("latch set while busy");
endmodule
`default_nettype wire

// ---- sim/spi_eeprom_command_logic_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_command_logic_test;
  import see_pkg::*;
  // ------------------------------------------------------------
  // clock, reset, both ends and the checker
  // ------------------------------------------------------------
  localparam int Wc = 1000; // short cycle, still long enough to poll status
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic busy;
  logic writeLatch;
  logic [1:0] protectLevel;
  logic [2:0] ctrl = 3'h0; // shadow of the host control register
  logic [7:0] rx;
  int nMismatch = 0;
  int checksDone = 0;
  always #25 clk = ~clk;
  see_link_if lnk();
  see_dev_end #(.WriteCycles(Wc)) i_see_dev_end (.clk(clk), .rst_n(rst_n), .link(lnk),
    .busy(busy), .writeLatch(writeLatch), .protectLevel(protectLevel));
  see_host_end i_see_host_end (.clk(clk), .rst_n(rst_n), .link(lnk), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata));
  see_link_monitor #(.WriteCycles(Wc)) i_see_link_monitor (.clk(clk), .rst_n(rst_n),
    .csN(lnk.csN), .sck(lnk.sck), .soOe(lnk.soOe), .holdN(lnk.holdN), .wpN(lnk.wpN),
    .busy(busy), .writeLatch(writeLatch), .protectLevel(protectLevel));
  // ------------------------------------------------------------
  // bus cycles and shared helpers
  // ------------------------------------------------------------
  task automatic finalReport();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata; // read data land after the taking edge
  endtask
  // pins follow the control register; cs only moves between bytes
  task automatic setc(input logic [2:0] v);
    ctrl = v;
    wr(HREG_CTRL, {5'h00, v});
    repeat (6) @(posedge clk);
  endtask
  // one byte each way; a stuck shifter counts as a mismatch
  task automatic xfer(input logic [7:0] tx, output logic [7:0] got);
    logic [7:0] s;
    int n;
    wr(HREG_TX, tx);
    n = 0;
    do
    begin
      rd(HREG_STAT, s);
      n++;
    end while (s[0] !== 1'b0 && n < 200);
    check({7'h00, s[0]}, 8'h00);
    rd(HREG_RX, got);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] ad, input logic [7:0] d, int nb);
    setc(ctrl | 3'h1);
    xfer(op, rx);
    if (nb > 0)
      xfer(ad, rx);
    if (nb > 1)
      xfer(d, rx);
  endtask
  task automatic one(input logic [7:0] op);
    cmd(op, 8'h00, 8'h00, 0);
    setc(ctrl & 3'h6);
  endtask
  // waits for a write cycle to start, or makes sure none does
  task automatic cycle(input logic want);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 12)
    begin
      @(posedge clk);
      n++;
    end
    check({7'h00, busy}, {7'h00, want});
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < Wc + 50)
    begin
      @(posedge clk);
      n++;
    end
    check({7'h00, busy}, 8'h00);
  endtask
  task automatic stat(input logic [7:0] exp);
    cmd(8'h05, 8'h00, 8'h00, 0);
    xfer(8'h00, rx);
    check(rx, exp);
    xfer(8'h3C, rx);
    check(rx, exp);
    setc(ctrl & 3'h6);
  endtask
  task automatic rdMem(input logic [7:0] op, input logic [7:0] ad, input logic [7:0] exp);
    cmd(op, ad, 8'h00, 1);
    xfer(8'h00, rx);
    check(rx, exp);
    setc(ctrl & 3'h6);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic tLatch();
    check({6'h00, protectLevel}, 8'h00);
    stat(8'h00);
    setc(3'h4);
    one(8'h0E);
    check({7'h00, writeLatch}, 8'h00);
    rd(HREG_CTRL, rx);
    check(rx, 8'h04);
    setc(3'h0);
    one(8'h06);
    check({7'h00, writeLatch}, 8'h01);
    stat(8'h02);
    setc(3'h4);
    one(8'h0C);
    check({7'h00, writeLatch}, 8'h00);
    setc(3'h0);
  endtask
  task automatic tPage();
    one(8'h06);
    cmd(8'h0A, 8'hFE, 8'hA1, 2);
    xfer(8'hA2, rx);
    xfer(8'hA3, rx);
    setc(3'h0);
    cycle(1'b1);
    stat(8'hFF);
    one(8'h04);
    check({7'h00, writeLatch}, 8'h01);
    idle();
    check({7'h00, writeLatch}, 8'h00);
    one(8'h06);
    cmd(8'h02, 8'h07, 8'hB0, 2);
    xfer(8'hB1, rx);
    setc(3'h0);
    cycle(1'b1);
    idle();
    cmd(8'h0B, 8'hFE, 8'h00, 1);
    xfer(8'h00, rx);
    check(rx, 8'hA1);
    xfer(8'h00, rx);
    check(rx, 8'hA2);
    xfer(8'h00, rx);
    check(rx, 8'hB1);
    setc(3'h0);
    rdMem(8'h0B, 8'hF8, 8'hA3);
    rdMem(8'h03, 8'h07, 8'hB0);
  endtask
  task automatic tProtect();
    one(8'h06);
    cmd(8'h01, 8'h04, 8'h00, 1);
    setc(3'h0);
    cycle(1'b1);
    idle();
    check({6'h00, protectLevel}, 8'h01);
    stat(8'h04);
    one(8'h06);
    cmd(8'h0A, 8'h80, 8'h55, 2);
    setc(3'h0);
    cycle(1'b0);
    one(8'h06);
    cmd(8'h0A, 8'h7F, 8'h66, 2);
    setc(3'h0);
    cycle(1'b1);
    idle();
    rdMem(8'h0B, 8'h7F, 8'h66);
  endtask
  task automatic tRefuse();
    one(8'h06);
    cmd(8'h02, 8'h10, 8'hAA, 2);
    setc(3'h5);
    setc(3'h4);
    cycle(1'b0);
    setc(3'h0);
    one(8'h04);
    cmd(8'h02, 8'h10, 8'hAA, 2);
    setc(3'h0);
    cycle(1'b0);
    cmd(8'h07, 8'h03, 8'h00, 1);
    xfer(8'h05, rx);
    check(rx, 8'hFF);
    setc(3'h0);
    stat(8'h04);
    cmd(8'h05, 8'h00, 8'h00, 0);
    check({7'h00, lnk.soBus}, 8'h00);
    // the device releases so while paused, so only the floating line is visible
    setc(3'h3);
    check({7'h00, lnk.soBus}, 8'h01);
    check({7'h00, lnk.soOe}, 8'h00);
    setc(3'h1);
    xfer(8'h00, rx);
    check(rx, 8'h04);
    setc(3'h0);
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    tLatch();
    tPage();
    tProtect();
    tRefuse();
    finalReport();
  end
  // the run needs about 14000 cycles; over four times that means a hang
  initial
  begin
    #3000000;
    nMismatch++;
    finalReport();
  end
endmodule
`default_nettype wire
